// ### hw/owc_top.sv
// Oscillator warm-up counter: cascaded 16-bit up-counter with match request.
// Assumes slow and fast source clocks arrive as pins, slower than 20 MHz,
// and software drives the register port synchronous to CLK_SYS_I.
`timescale 1ns/1ps
module owc_top (
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   // Register port
   input wire owc_pkg::owc_bus_req_type BUS_REQ_I,
   output logic [owc_pkg::OWC_DATA_W-1:0] BUS_RDATA_O,
   // Source clock pins
   input wire logic SLOW_CLK_I,
   input wire logic FAST_CLK_I,
   // Clock generator control
   output owc_pkg::owc_clk_ctrl_type CLK_CTRL_O,
   // Match request, one cycle
   output logic PAIR_MATCH_IRQ_O
);
   import owc_pkg::*;

   logic [7:0] lower_ctrl_r;
   logic [7:0] upper_ctrl_r;
   logic [7:0] cmp_lo_r;
   logic [7:0] cmp_hi_r;
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic lower_tff_r;
   logic upper_tff_r;
   logic match_seen_r;
   logic irq_r;
   logic [OWC_DATA_W-1:0] rdata_r;
   owc_clk_ctrl_type clk_ctrl_r;
   logic [OWC_NUM_SRC-1:0] src_async;
   logic [OWC_NUM_SRC-1:0] src_tick;
   logic wr_lower;
   logic wr_upper;
   logic wr_status;
   logic [2:0] cksel;
   logic run;
   logic warmup_on;
   logic tick;
   logic match;
   logic [15:0] target;

   assign src_async[OWC_SRC_SLOW] = SLOW_CLK_I;
   assign src_async[OWC_SRC_FAST] = FAST_CLK_I;

   // Both pins pass two flip-flops before use
   genvar gi;
   generate
      for (gi = 0; gi < OWC_NUM_SRC; gi++) begin : g_src
         owc_edge_sync u_sync (
            .clk_i(CLK_SYS_I),
            .rst_i(RST_I),
            .async_i(src_async[gi]),
            .rise_o(src_tick[gi])
         );
      end
   endgenerate

   assign wr_lower = BUS_REQ_I.wr && (BUS_REQ_I.addr == OWC_LOWER_CTRL_OFS);
   assign wr_upper = BUS_REQ_I.wr && (BUS_REQ_I.addr == OWC_UPPER_CTRL_OFS);
   assign wr_status = BUS_REQ_I.wr && (BUS_REQ_I.addr == OWC_STATUS_OFS);

   // Control registers
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         lower_ctrl_r <= OWC_CTRL_RST;
         upper_ctrl_r <= OWC_CTRL_RST;
         cmp_lo_r <= OWC_CMP_RST;
         cmp_hi_r <= OWC_CMP_RST;
      end else if (BUS_REQ_I.wr) begin
         case (BUS_REQ_I.addr)
            OWC_LOWER_CTRL_OFS: begin
               lower_ctrl_r <= BUS_REQ_I.wdata[7:0];
            end
            OWC_UPPER_CTRL_OFS: begin
               upper_ctrl_r <= BUS_REQ_I.wdata[7:0];
            end
            OWC_CMP_LO_OFS: begin
               cmp_lo_r <= BUS_REQ_I.wdata[7:0];
            end
            OWC_CMP_HI_OFS: begin
               cmp_hi_r <= BUS_REQ_I.wdata[7:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Toggle flip-flops take their initial value on each control write
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         lower_tff_r <= 1'b0;
         upper_tff_r <= 1'b0;
      end else begin
         if (wr_lower) begin
            lower_tff_r <= BUS_REQ_I.wdata[OWC_TFF_BIT];
         end
         if (wr_upper) begin
            upper_tff_r <= BUS_REQ_I.wdata[OWC_TFF_BIT];
         end
      end
   end

   // Clock generator bits; the switch-over order is left to software
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         clk_ctrl_r <= '0;
      end else if (BUS_REQ_I.wr && (BUS_REQ_I.addr == OWC_SYSCLK_OFS)) begin
         clk_ctrl_r.system_clock_select <= BUS_REQ_I.wdata[OWC_SYS_SEL_BIT];
         clk_ctrl_r.slow_osc_enable <= BUS_REQ_I.wdata[OWC_SLOW_EN_BIT];
         clk_ctrl_r.fast_osc_enable <= BUS_REQ_I.wdata[OWC_FAST_EN_BIT];
      end
   end

   // Source and mode decode
   assign cksel = lower_ctrl_r[OWC_CKSEL_MSB:OWC_CKSEL_LSB];
   assign run = upper_ctrl_r[OWC_RUN_BIT];
   assign warmup_on = run &&
      (upper_ctrl_r[OWC_MODE_MSB:OWC_MODE_LSB] == OWC_MODE_WARMUP) &&
      (lower_ctrl_r[OWC_MODE_MSB:OWC_MODE_LSB] == OWC_MODE_CASCADE);

   // Other source codes belong to modes not built here
   always_comb begin
      case (cksel)
         OWC_CKSEL_SLOW: tick = src_tick[OWC_SRC_SLOW];
         OWC_CKSEL_FAST: tick = src_tick[OWC_SRC_FAST];
         default: tick = 1'b0;
      endcase
   end

   // Low compare byte ignored, so the interval is whole steps of 256
   assign target = {cmp_hi_r, OWC_BYTE_ZERO};
   assign count_nxt = count_r + OWC_COUNT_ONE;
   // Upper byte zero wraps the full 65536 steps
   assign match = warmup_on && tick && (count_nxt == target);

   // Interval equals target ticks of the source clock
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         count_r <= OWC_COUNT_RST;
      end else if (!run) begin
         count_r <= OWC_COUNT_RST;
      end else if (match) begin
         count_r <= OWC_COUNT_RST;
      end else if (warmup_on && tick) begin
         count_r <= count_nxt;
      end
   end

   // Match request pulse
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= match;
      end
   end

   // Sticky match flag, write one clears, a new match wins
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         match_seen_r <= 1'b0;
      end else if (match) begin
         match_seen_r <= 1'b1;
      end else if (wr_status && BUS_REQ_I.wdata[OWC_ST_MATCH_BIT]) begin
         match_seen_r <= 1'b0;
      end
   end

   // Read data, one cycle after the strobe only
   always_ff @(posedge CLK_SYS_I) begin
      if (RST_I) begin
         rdata_r <= OWC_WORD_ZERO;
      end else if (BUS_REQ_I.rd) begin
         rdata_r <= OWC_WORD_ZERO;
         case (BUS_REQ_I.addr)
            OWC_LOWER_CTRL_OFS: rdata_r[7:0] <= lower_ctrl_r;
            OWC_UPPER_CTRL_OFS: rdata_r[7:0] <= upper_ctrl_r;
            OWC_CMP_LO_OFS: rdata_r[7:0] <= cmp_lo_r;
            OWC_CMP_HI_OFS: rdata_r[7:0] <= cmp_hi_r;
            OWC_COUNT_LO_OFS: rdata_r[7:0] <= count_r[7:0];
            OWC_COUNT_HI_OFS: rdata_r[7:0] <= count_r[15:8];
            OWC_SYSCLK_OFS: begin
               rdata_r[OWC_SYS_SEL_BIT] <= clk_ctrl_r.system_clock_select;
               rdata_r[OWC_SLOW_EN_BIT] <= clk_ctrl_r.slow_osc_enable;
               rdata_r[OWC_FAST_EN_BIT] <= clk_ctrl_r.fast_osc_enable;
            end
            OWC_STATUS_OFS: begin
               rdata_r[OWC_ST_MATCH_BIT] <= match_seen_r;
               rdata_r[OWC_ST_RUN_BIT] <= warmup_on;
               rdata_r[OWC_ST_LTFF_BIT] <= lower_tff_r;
               rdata_r[OWC_ST_UTFF_BIT] <= upper_tff_r;
            end
            default: begin
            end
         endcase
      end else begin
         rdata_r <= OWC_WORD_ZERO;
      end
   end

   assign BUS_RDATA_O = rdata_r;
   assign CLK_CTRL_O = clk_ctrl_r;
   assign PAIR_MATCH_IRQ_O = irq_r;
endmodule

// ### hw/owc_pkg.sv
// Package of the oscillator warm-up counter: register map, fields, types.
// Assumes a single 40 MHz system clock and a plain register port.
package owc_pkg;

   // System clock
   localparam int unsigned OWC_SYS_HZ = 40_000_000;

   // Register port widths
   localparam int unsigned OWC_ADDR_W = 8;
   localparam int unsigned OWC_DATA_W = 32;

   // Register byte offsets
   localparam logic [7:0] OWC_LOWER_CTRL_OFS = 8'h00;
   localparam logic [7:0] OWC_UPPER_CTRL_OFS = 8'h04;
   localparam logic [7:0] OWC_CMP_LO_OFS = 8'h08;
   localparam logic [7:0] OWC_CMP_HI_OFS = 8'h0C;
   localparam logic [7:0] OWC_COUNT_LO_OFS = 8'h10;
   localparam logic [7:0] OWC_COUNT_HI_OFS = 8'h14;
   localparam logic [7:0] OWC_SYSCLK_OFS = 8'h18;
   localparam logic [7:0] OWC_STATUS_OFS = 8'h1C;

   // Control register fields
   localparam int unsigned OWC_TFF_BIT = 7;
   localparam int unsigned OWC_CKSEL_LSB = 4;
   localparam int unsigned OWC_CKSEL_MSB = 6;
   localparam int unsigned OWC_RUN_BIT = 3;
   localparam int unsigned OWC_MODE_LSB = 0;
   localparam int unsigned OWC_MODE_MSB = 2;

   // Clock select and mode codes
   localparam logic [2:0] OWC_CKSEL_SLOW = 3'h4;
   localparam logic [2:0] OWC_CKSEL_FAST = 3'h6;
   localparam logic [2:0] OWC_MODE_CASCADE = 3'h3;
   localparam logic [2:0] OWC_MODE_WARMUP = 3'h5;

   // System clock register fields
   localparam int unsigned OWC_SYS_SEL_BIT = 5;
   localparam int unsigned OWC_SLOW_EN_BIT = 6;
   localparam int unsigned OWC_FAST_EN_BIT = 7;

   // Status register fields
   localparam int unsigned OWC_ST_MATCH_BIT = 0;
   localparam int unsigned OWC_ST_RUN_BIT = 1;
   localparam int unsigned OWC_ST_LTFF_BIT = 2;
   localparam int unsigned OWC_ST_UTFF_BIT = 3;

   // Reset values and fixed constants
   localparam logic [7:0] OWC_CTRL_RST = 8'h00;
   localparam logic [7:0] OWC_CMP_RST = 8'hFF;
   localparam logic [15:0] OWC_COUNT_RST = 16'h0000;
   localparam logic [15:0] OWC_COUNT_ONE = 16'h0001;
   localparam logic [7:0] OWC_BYTE_ZERO = 8'h00;
   localparam logic [31:0] OWC_WORD_ZERO = 32'h0000_0000;

   // Tick sources
   localparam int unsigned OWC_NUM_SRC = 2;
   localparam int unsigned OWC_SRC_SLOW = 0;
   localparam int unsigned OWC_SRC_FAST = 1;

   // Nominal warm-up figures for a slow clock of 32.768 kHz
   localparam logic [15:0] OWC_CMP_MIN = 16'h0100;
   localparam logic [15:0] OWC_CMP_MAX = 16'hFF00;

   // Register port request
   typedef struct packed {
      logic [OWC_ADDR_W-1:0] addr;
      logic [OWC_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } owc_bus_req_type;

   // Outputs toward the clock generator
   typedef struct packed {
      logic fast_osc_enable;
      logic slow_osc_enable;
      logic system_clock_select;
   } owc_clk_ctrl_type;

endpackage

// ### hw/owc_edge_sync.sv
// Two-stage synchroniser with rising-edge detector for one source clock.
// Assumes the source runs below half the system clock rate.
`timescale 1ns/1ps
module owc_edge_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Asynchronous source
   input wire logic async_i,
   // One-cycle tick on each rising edge
   output logic rise_o
);
   logic meta_r;
   logic sync_r;
   logic last_r;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign rise_o = sync_r & ~last_r;
endmodule

// ### verif/owc_props.sv
// Port checker of the warm-up counter.
// Assumes a bind to owc_top; sees its ports only.
`timescale 1ns/1ps
module owc_props (
   // Clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   // Register port
   input wire owc_pkg::owc_bus_req_type BUS_REQ_I,
   input wire logic [owc_pkg::OWC_DATA_W-1:0] BUS_RDATA_O,
   // Source pins and outputs
   input wire logic SLOW_CLK_I,
   input wire logic FAST_CLK_I,
   input wire owc_pkg::owc_clk_ctrl_type CLK_CTRL_O,
   input wire logic PAIR_MATCH_IRQ_O
);
   import owc_pkg::*;
   owc_bus_req_type q;
   assign q = BUS_REQ_I;
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   a_irq_one_cycle: assert property (
      PAIR_MATCH_IRQ_O |=> !PAIR_MATCH_IRQ_O)
      else $error("match request longer than one cycle");
   a_rdata_idle_zero: assert property (
      !q.rd |=> BUS_RDATA_O == 32'h0000_0000)
      else $error("read data outside read cycle");
   a_sysclk_write: assert property (
      (q.wr && q.addr == OWC_SYSCLK_OFS) |=>
      CLK_CTRL_O == $past(q.wdata[7:5]))
      else $error("clock control not written");
   a_sysclk_hold: assert property (
      !(q.wr && q.addr == OWC_SYSCLK_OFS) |=> $stable(CLK_CTRL_O))
      else $error("clock control changed without write");
   a_lower_readback: assert property (
      (q.wr && q.addr == OWC_LOWER_CTRL_OFS) ##1
      (q.rd && q.addr == OWC_LOWER_CTRL_OFS) |=>
      BUS_RDATA_O == {24'h00_0000, $past(q.wdata[7:0], 2)})
      else $error("lower control readback wrong");
   a_upper_readback: assert property (
      (q.wr && q.addr == OWC_UPPER_CTRL_OFS) ##1
      (q.rd && q.addr == OWC_UPPER_CTRL_OFS) |=>
      BUS_RDATA_O == {24'h00_0000, $past(q.wdata[7:0], 2)})
      else $error("upper control readback wrong");
   a_cmp_readback: assert property (
      (q.wr && q.addr == OWC_CMP_HI_OFS) ##1
      (q.rd && q.addr == OWC_CMP_HI_OFS) |=>
      BUS_RDATA_O == {24'h00_0000, $past(q.wdata[7:0], 2)})
      else $error("compare readback wrong");
   // Run is registered, so the count clears on the edge after the stop write; allow one settling cycle
   a_stop_clears: assert property (
      (q.wr && q.addr == OWC_UPPER_CTRL_OFS && !q.wdata[OWC_RUN_BIT]) ##1
      !q.wr ##1
      (q.rd && q.addr == OWC_COUNT_LO_OFS) |=> BUS_RDATA_O == 32'h0000_0000)
      else $error("count not cleared on stop");
   c_match: cover property (PAIR_MATCH_IRQ_O);
   c_start: cover property (q.wr && q.wdata[OWC_RUN_BIT]);
   c_sysclk: cover property (q.wr && q.addr == OWC_SYSCLK_OFS);
endmodule

// ### verif/oscillator_warmup_counter_tb.sv
// Self-checking bench of the oscillator warm-up counter.
// Assumes owc_pkg, owc_top and owc_props are compiled first.
`timescale 1ns/1ps
module oscillator_warmup_counter_tb;
   import owc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, slow = 1'b0, fast = 1'b0, irq;
   owc_bus_req_type req = '0;
   logic [31:0] rdata;
   owc_clk_ctrl_type ctrl;
   int err_total = 0, n_tests = 0, irq_n = 0;
   int seed = 32'h5a5f_b9ea;
   owc_top uut (.CLK_SYS_I(clk), .RST_I(rst), .BUS_REQ_I(req),
      .BUS_RDATA_O(rdata), .SLOW_CLK_I(slow), .FAST_CLK_I(fast),
      .CLK_CTRL_O(ctrl), .PAIR_MATCH_IRQ_O(irq));
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) if (irq === 1'b1) irq_n <= irq_n + 1;
   function automatic int ticks_for(input logic [7:0] hi);
      return (hi == 8'h00) ? 65536 : int'(hi) * 256;
   endfunction
   task automatic bus(input logic [7:0] a, input logic [31:0] d,
         input logic w, input logic r);
      @(posedge clk);
      req <= {a, d, w, r};
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, {24'h00_0000, d}, 1'b1, 1'b0);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(a, 32'h0000_0000, 1'b0, 1'b1);
      bus(8'h00, 32'h0000_0000, 1'b0, 1'b0);
      #1 chk(rdata, exp);
   endtask
   // Pins pulse at a quarter of the system rate, well inside the sync limit
   task automatic ticks(input int k, input logic f);
      bus(8'h00, 32'h0000_0000, 1'b0, 1'b0);
      repeat (k) begin
         if (f) fast <= 1'b1; else slow <= 1'b1;
         repeat (2) @(posedge clk);
         fast <= 1'b0;
         slow <= 1'b0;
         repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask
   task automatic run(input logic [7:0] sel, input logic [7:0] hi,
         input logic f);
      int n, k;
      n = ticks_for(hi);
      k = 1 + ({$random(seed)} % (n - 1));
      wr(OWC_LOWER_CTRL_OFS, sel);
      rd(OWC_LOWER_CTRL_OFS, {24'h00_0000, sel});
      wr(OWC_CMP_LO_OFS, 8'($random(seed)));
      wr(OWC_CMP_HI_OFS, hi);
      rd(OWC_CMP_HI_OFS, {24'h00_0000, hi});
      wr(OWC_UPPER_CTRL_OFS, 8'h05);
      rd(OWC_UPPER_CTRL_OFS, 32'h0000_0005);
      ticks(3, f);
      rd(OWC_COUNT_LO_OFS, 32'h0000_0000);
      wr(OWC_UPPER_CTRL_OFS, 8'h0D);
      irq_n = 0;
      ticks(k, f);
      rd(OWC_COUNT_LO_OFS, k % 256);
      rd(OWC_COUNT_HI_OFS, k / 256);
      ticks(n - k, f);
      chk(irq_n, 1);
      rd(OWC_COUNT_LO_OFS, 32'h0000_0000);
      wr(OWC_UPPER_CTRL_OFS, 8'h05);
      bus(8'h00, 32'h0000_0000, 1'b0, 1'b0);
      rd(OWC_COUNT_LO_OFS, 32'h0000_0000);
      rd(OWC_STATUS_OFS, 32'h0000_0001);
      wr(OWC_STATUS_OFS, 8'h01);
      rd(OWC_STATUS_OFS, 32'h0000_0000);
      ticks(2, f);
      chk(irq_n, 1);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Longest run is three compare steps of fast ticks, under 8000 cycles
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      results();
   end
   initial begin
      logic [7:0] hi;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(OWC_CMP_HI_OFS, 32'h0000_00FF);
      rd(OWC_STATUS_OFS, 32'h0000_0000);
      rd(8'h40, 32'h0000_0000);
      wr(OWC_SYSCLK_OFS, 8'hC0);
      run(8'h43, 8'h01, 1'b0);
      wr(OWC_SYSCLK_OFS, 8'hE0);
      wr(OWC_SYSCLK_OFS, 8'h60);
      rd(OWC_SYSCLK_OFS, 32'h0000_0060);
      chk(32'(ctrl), 32'h0000_0003);
      wr(OWC_SYSCLK_OFS, 8'hE0);
      hi = 8'(1 + {$random(seed)} % 3);
      run(8'h63, hi, 1'b1);
      // Fast stays on; slow is the one stopped after this switch
      wr(OWC_SYSCLK_OFS, 8'hC0);
      wr(OWC_SYSCLK_OFS, 8'h80);
      rd(OWC_SYSCLK_OFS, 32'h0000_0080);
      chk(32'(ctrl), 32'h0000_0004);
      results();
   end
endmodule
bind owc_top owc_props chk_i (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
   .BUS_REQ_I(BUS_REQ_I), .BUS_RDATA_O(BUS_RDATA_O),
   .SLOW_CLK_I(SLOW_CLK_I), .FAST_CLK_I(FAST_CLK_I),
   .CLK_CTRL_O(CLK_CTRL_O), .PAIR_MATCH_IRQ_O(PAIR_MATCH_IRQ_O));
